// ---- smlr_regs.sv ----
/*
  Signal monitor and level alarm register bank with an APB slave and peak detector.
  Assumes samples and the decimated output clock enable are on clk; zero wait APB.
*/
`timescale 1ns/100ps
`default_nettype none
module smlr_regs #(
  parameter int SAMPLE_W = 13
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dec_clk_en,
  input wire logic [SAMPLE_W-1:0] sample_mag,
  output logic [12:0] level_upper_threshold,
  output logic [12:0] level_lower_threshold,
  output logic [15:0] level_dwell,
  output logic [1:0] monitor_sync_mode,
  output logic [1:0] dc_sync_mode,
  output logic tuning_oscillator_reset
);
  // Field sizes of the byte registers and the monitor fields
  localparam int BYTE_W = 8;
  localparam int MAG_W = 13;
  localparam int RES_W = 20;
  localparam int PER_W = 24;
  localparam logic [PER_W-1:0] PER_STEP = 24'h000001;

  // Writable bit masks; spare bits are dropped on write so they always read zero
  localparam logic [7:0] MASK_HI5 = 8'h1F;
  localparam logic [7:0] MASK_SYNC = 8'h03;
  localparam logic [7:0] MASK_MCTL = 8'h02;
  localparam logic [7:0] MASK_RCTL = 8'h01;
  localparam logic [7:0] MASK_DSYNC = 8'h13;

  // Elaboration checks: the result layout only serves a 13-bit magnitude
  if (SAMPLE_W != MAG_W)
  begin
    $error("SAMPLE_W must be 13");
  end
  if (smlr_pkg::RES_PEAK_LSB + MAG_W != RES_W)
  begin
    $error("Peak field must end at the top result bit");
  end
  if (smlr_pkg::BIT_PEAK_EN >= BYTE_W || smlr_pkg::BIT_UPDATE >= BYTE_W)
  begin
    $error("Monitor control bits must lie inside a byte");
  end
  if (smlr_pkg::BIT_RSEL >= BYTE_W || smlr_pkg::BIT_OSC_RST >= BYTE_W)
  begin
    $error("Result and oscillator bits must lie inside a byte");
  end
  if (3 * BYTE_W != PER_W)
  begin
    $error("Period must fill its three byte registers");
  end
  if (RES_W > 3 * BYTE_W)
  begin
    $error("Result must fit its three byte registers");
  end

  // Word compare shared by every register select
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction

  // Keeps the writable bits of a written byte
  function automatic logic [7:0] keep_bits(input logic [7:0] value, input logic [7:0] mask);
    return value & mask;
  endfunction

  // Counter step; shared by the period end test and the count itself
  function automatic logic [PER_W-1:0] step(input logic [PER_W-1:0] count);
    return count + PER_STEP;
  endfunction

  logic [7:0] up_lo, up_hi, low_lo, low_hi, dw_lo, dw_hi, sync_c, mctl;
  logic [7:0] per0, per1, per2, rctl, dsync;
  logic [19:0] result;
  logic [7:0] pcount;
  logic [23:0] per_cnt;
  logic [12:0] peak;
  logic [7:0] period_num;

  // Level alarm selects
  wire sel_up_lo = addr_is(paddr, smlr_pkg::OFF_UP_LO);
  wire sel_up_hi = addr_is(paddr, smlr_pkg::OFF_UP_HI);
  wire sel_low_lo = addr_is(paddr, smlr_pkg::OFF_LOW_LO);
  wire sel_low_hi = addr_is(paddr, smlr_pkg::OFF_LOW_HI);
  wire sel_dw_lo = addr_is(paddr, smlr_pkg::OFF_DW_LO);
  wire sel_dw_hi = addr_is(paddr, smlr_pkg::OFF_DW_HI);
  // Monitor setup selects
  wire sel_sync = addr_is(paddr, smlr_pkg::OFF_SYNC);
  wire sel_mctl = addr_is(paddr, smlr_pkg::OFF_MCTL);
  wire sel_per0 = addr_is(paddr, smlr_pkg::OFF_PER0);
  wire sel_per1 = addr_is(paddr, smlr_pkg::OFF_PER1);
  wire sel_per2 = addr_is(paddr, smlr_pkg::OFF_PER2);
  wire sel_rctl = addr_is(paddr, smlr_pkg::OFF_RCTL);
  // Monitor result selects; these words are read only
  wire sel_res0 = addr_is(paddr, smlr_pkg::OFF_RES0);
  wire sel_res1 = addr_is(paddr, smlr_pkg::OFF_RES1);
  wire sel_res2 = addr_is(paddr, smlr_pkg::OFF_RES2);
  wire sel_pcnt = addr_is(paddr, smlr_pkg::OFF_PCNT);
  // Downconverter select
  wire sel_dsync = addr_is(paddr, smlr_pkg::OFF_DSYNC);
  // Whole words only are decoded, so low address bits never alias a register
  wire hit = sel_up_lo || sel_up_hi || sel_low_lo || sel_low_hi || sel_dw_lo || sel_dw_hi ||
    sel_sync || sel_mctl || sel_per0 || sel_per1 || sel_per2 || sel_rctl ||
    sel_res0 || sel_res1 || sel_res2 || sel_pcnt || sel_dsync;

  // Write decode in the access phase, read decode in the setup phase; pready is high from the first edge out of reset so every access completes at once
  wire wr = psel && penable && pwrite;
  wire rd_en = psel && !penable && !pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire update = wr && sel_rctl && wd[smlr_pkg::BIT_UPDATE];
  wire peak_en = mctl[smlr_pkg::BIT_PEAK_EN];
  wire [PER_W-1:0] period = {per2, per1, per0};
  // Period 0 behaves as 1, so the counter can never run past its end
  wire period_end = dec_clk_en && (step(per_cnt) >= period);
  // Result from the peak; bits below the magnitude are zero
  wire [RES_W-1:0] next_result = rctl[smlr_pkg::BIT_RSEL] ?
    {peak, {smlr_pkg::RES_PEAK_LSB{1'b0}}} : {RES_W{1'b0}};

  // Read mux; unmapped words read zero
  logic [7:0] rbyte;
  always_comb
  begin
    rbyte = 8'h00;
    unique case (paddr)
      smlr_pkg::OFF_UP_LO: rbyte = up_lo;
      smlr_pkg::OFF_UP_HI: rbyte = {3'h0, up_hi[4:0]};
      smlr_pkg::OFF_LOW_LO: rbyte = low_lo;
      smlr_pkg::OFF_LOW_HI: rbyte = {3'h0, low_hi[4:0]};
      smlr_pkg::OFF_DW_LO: rbyte = dw_lo;
      smlr_pkg::OFF_DW_HI: rbyte = dw_hi;
      smlr_pkg::OFF_SYNC: rbyte = sync_c;
      smlr_pkg::OFF_MCTL: rbyte = mctl;
      smlr_pkg::OFF_PER0: rbyte = per0;
      smlr_pkg::OFF_PER1: rbyte = per1;
      smlr_pkg::OFF_PER2: rbyte = per2;
      smlr_pkg::OFF_RCTL: rbyte = rctl;
      smlr_pkg::OFF_RES0: rbyte = result[7:0];
      smlr_pkg::OFF_RES1: rbyte = result[15:8];
      smlr_pkg::OFF_RES2: rbyte = {4'h0, result[19:16]};
      smlr_pkg::OFF_PCNT: rbyte = pcount;
      smlr_pkg::OFF_DSYNC: rbyte = dsync;
      default: rbyte = 8'h00;
    endcase
  end

  // Bus answer registered in the setup cycle so it is valid in the access phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      pslverr <= psel && !penable && !hit;
    end
  end

  // Read data holds until the next read setup, so a slow master still sees it
  always_ff @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (rd_en)
      prdata <= {24'h000000, rbyte};
  end

  // Level alarm thresholds; the high bytes keep five bits, the three above read zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      up_lo <= 8'h00;
      up_hi <= 8'h00;
      low_lo <= 8'h00;
      low_hi <= 8'h00;
    end
    else if (wr)
    begin
      if (sel_up_lo)
        up_lo <= wd;
      if (sel_up_hi)
        up_hi <= keep_bits(wd, MASK_HI5);
      if (sel_low_lo)
        low_lo <= wd;
      if (sel_low_hi)
        low_hi <= keep_bits(wd, MASK_HI5);
    end
  end

  // Level alarm dwell time, low byte first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dw_lo <= 8'h00;
      dw_hi <= 8'h00;
    end
    else if (wr)
    begin
      if (sel_dw_lo)
        dw_lo <= wd;
      if (sel_dw_hi)
        dw_hi <= wd;
    end
  end

  // Monitor setup: sync mode, enable, period and result control
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_c <= 8'h00;
      mctl <= 8'h00;
      per0 <= smlr_pkg::RST_PER0;
      per1 <= 8'h00;
      per2 <= 8'h00;
      rctl <= smlr_pkg::RST_RCTL;
    end
    else if (wr)
    begin
      if (sel_sync)
        sync_c <= keep_bits(wd, MASK_SYNC);
      if (sel_mctl)
        mctl <= keep_bits(wd, MASK_MCTL);
      if (sel_per0)
        per0 <= wd;
      if (sel_per1)
        per1 <= wd;
      if (sel_per2)
        per2 <= wd;
      // Update bit is never stored, so it reads back cleared
      if (sel_rctl)
        rctl <= keep_bits(wd, MASK_RCTL);
    end
  end

  // Downconverter sync control; only the mode and soft reset bits are kept
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dsync <= 8'h00;
    end
    else if (wr)
    begin
      if (sel_dsync)
        dsync <= keep_bits(wd, MASK_DSYNC);
    end
  end

  // Peak tracker; a sample at period end starts the new period's maximum
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      per_cnt <= 24'h000000;
      peak <= 13'h0000;
      period_num <= 8'h00;
    end
    // Disabled: clear the counter and forget the peak so a later enable starts clean
    else if (!peak_en)
    begin
      per_cnt <= 24'h000000;
      peak <= 13'h0000;
    end
    else if (dec_clk_en)
    begin
      if (period_end)
      begin
        per_cnt <= 24'h000000;
        peak <= sample_mag;
        period_num <= period_num + 8'h01;
      end
      else
      begin
        per_cnt <= step(per_cnt);
        if (sample_mag > peak) peak <= sample_mag;
      end
    end
  end

  // Snapshot on update write only
  // Software reads a coherent result because nothing else refreshes these bytes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result <= 20'h00000;
      pcount <= 8'h00;
    end
    else if (update)
    begin
      result <= next_result;
      pcount <= period_num;
    end
  end

  // Outputs to the level alarm and monitor logic, one cycle behind the registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level_upper_threshold <= 13'h0000;
      level_lower_threshold <= 13'h0000;
      level_dwell <= 16'h0000;
      monitor_sync_mode <= 2'h0;
    end
    else
    begin
      level_upper_threshold <= {up_hi[4:0], up_lo};
      level_lower_threshold <= {low_hi[4:0], low_lo};
      level_dwell <= {dw_hi, dw_lo};
      monitor_sync_mode <= sync_c[1:0];
    end
  end

  // Outputs to the downconverter; the soft reset holds while the bit stays set
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dc_sync_mode <= 2'h0;
      tuning_oscillator_reset <= 1'b0;
    end
    else
    begin
      dc_sync_mode <= dsync[1:0];
      tuning_oscillator_reset <= dsync[smlr_pkg::BIT_OSC_RST];
    end
  end
endmodule
`default_nettype wire

// ---- smlr_pkg.sv ----
/*
  Constants for the signal monitor and level alarm register bank.
  Assumes an APB master on a 50 MHz clock and byte-wide registers in word slots.
*/
// Operation
// - 13-bit lower threshold over two registers
// - 16-bit dwell time over two bytes
// - Monitor control bit enables peak detector
// - 24-bit period, low byte resets 0x80
// - Period counted in decimated output cycles
// - Update bit latches results, self clears
// - Selection bit picks peak detector, resets 0x01
// - Peak magnitude in result bits 19:7
// - 20-bit result over three read-only bytes
// - 8-bit period count refreshed on update
// - Oscillator soft reset bit holds tuning oscillators
// - 13-bit upper threshold over two registers
`default_nettype none
package smlr_pkg;
  localparam logic [11:0] OFF_UP_LO = 12'h247 << 2;
  localparam logic [11:0] OFF_UP_HI = 12'h248 << 2;
  localparam logic [11:0] OFF_LOW_LO = 12'h249 << 2;
  localparam logic [11:0] OFF_LOW_HI = 12'h24A << 2;
  localparam logic [11:0] OFF_DW_LO = 12'h24B << 2;
  localparam logic [11:0] OFF_DW_HI = 12'h24C << 2;
  localparam logic [11:0] OFF_SYNC = 12'h26F << 2;
  localparam logic [11:0] OFF_MCTL = 12'h270 << 2;
  localparam logic [11:0] OFF_PER0 = 12'h271 << 2;
  localparam logic [11:0] OFF_PER1 = 12'h272 << 2;
  localparam logic [11:0] OFF_PER2 = 12'h273 << 2;
  localparam logic [11:0] OFF_RCTL = 12'h274 << 2;
  localparam logic [11:0] OFF_RES0 = 12'h275 << 2;
  localparam logic [11:0] OFF_RES1 = 12'h276 << 2;
  localparam logic [11:0] OFF_RES2 = 12'h277 << 2;
  localparam logic [11:0] OFF_PCNT = 12'h278 << 2;
  localparam logic [11:0] OFF_DSYNC = 12'h300 << 2;
  localparam logic [7:0] RST_PER0 = 8'h80;
  localparam logic [7:0] RST_RCTL = 8'h01;
  localparam int BIT_PEAK_EN = 1;
  localparam int BIT_UPDATE = 4;
  localparam int BIT_RSEL = 0;
  localparam int BIT_OSC_RST = 4;
  localparam int RES_PEAK_LSB = 7;
endpackage
`default_nettype wire

// ---- smlr_chk.sv ----
/* Assertion checker bound into smlr_regs.
   Sees top ports only; expects the zero-wait APB slave of the note. */
`timescale 1ns/100ps
`default_nettype none
module smlr_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [12:0] level_upper_threshold,
  input wire logic [12:0] level_lower_threshold,
  input wire logic [15:0] level_dwell,
  input wire logic tuning_oscillator_reset
);
  // Access phase decode; a written level shows two edges later
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_lower_hi: assert property (wr && paddr == smlr_pkg::OFF_LOW_HI |=> ##1
    level_lower_threshold[12:8] == $past(pwdata[4:0], 2)) else $error("lower threshold high");
  a_dwell_hi: assert property (wr && paddr == smlr_pkg::OFF_DW_HI |=> ##1
    level_dwell[15:8] == $past(pwdata[7:0], 2)) else $error("dwell high byte");
  a_upper_lo: assert property (wr && paddr == smlr_pkg::OFF_UP_LO |=> ##1
    level_upper_threshold[7:0] == $past(pwdata[7:0], 2)) else $error("upper threshold low");
  a_osc_reset: assert property (wr && paddr == smlr_pkg::OFF_DSYNC |=> ##1
    tuning_oscillator_reset == $past(pwdata[4], 2)) else $error("oscillator reset level");
  a_mctl_spare: assert property (rd && paddr == smlr_pkg::OFF_MCTL
    |-> prdata[7:2] == 0 && !prdata[0]) else $error("monitor control spare bits");
  a_res_top: assert property (rd && paddr == smlr_pkg::OFF_RES2
    |-> prdata[31:4] == 0) else $error("result top nibble");
  a_res_low: assert property (rd && paddr == smlr_pkg::OFF_RES0
    |-> prdata[6:0] == 0) else $error("result low bits");
  a_update_clear: assert property (rd && paddr == smlr_pkg::OFF_RCTL
    |-> !prdata[4] && prdata[31:8] == 0) else $error("update bit not clear");
  // Main scenarios reached
  c_update: cover property (wr && paddr == smlr_pkg::OFF_RCTL && pwdata[4]);
  c_osc: cover property (tuning_oscillator_reset && pready);
  c_read: cover property (rd && paddr == smlr_pkg::OFF_RES1);
endmodule
bind smlr_regs smlr_chk i_smlr_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .level_upper_threshold, .level_lower_threshold, .level_dwell,
  .tuning_oscillator_reset);
`default_nettype wire

// ---- tb_top.sv ----
/* Self-checking bench for smlr_regs.
   The bench is the APB master and the decimated sample source. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic dec_clk_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [12:0] sample_mag = 13'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, tuning_oscillator_reset, perr;
  logic [12:0] level_upper_threshold, level_lower_threshold;
  logic [15:0] level_dwell;
  logic [1:0] monitor_sync_mode, dc_sync_mode;
  logic [7:0] q;
  int err_count = 0, samples_checked = 0, cycles = 0;

  smlr_regs i_smlr_regs (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dec_clk_en, .sample_mag, .level_upper_threshold, .level_dwell,
    .level_lower_threshold, .monitor_sync_mode, .dc_sync_mode, .tuning_oscillator_reset);

  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  // Cut a hang short; the run needs well under a thousand cycles
  always @(posedge clk)
    if (++cycles == 4000)
      give_verdict(1);

  task automatic give_verdict(input int extra);
    err_count += extra;
    $display("mismatches %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits on pready, takes data at that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n++ < 20)
      @(posedge clk);
    q = prdata[7:0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  // One decimated sample; off-strobe samples are loud so they must be ignored
  task automatic pulse(input logic [12:0] m);
    @(posedge clk);
    dec_clk_en <= 1'b1;
    sample_mag <= m;
    @(posedge clk);
    dec_clk_en <= 1'b0;
    sample_mag <= 13'h1FFF;
  endtask

  task automatic t_reset_values();
    for (int i = 12'h247; i <= 12'h300; i++)
      if (i < 12'h24D || (i > 12'h26E && i < 12'h279) || i == 12'h300)
        rd(12'(i * 4), i == 12'h271 ? 8'h80 : {7'h00, i == 12'h274});
  endtask

  // Levels, spare bits masked, then an unmapped and a read-only write
  task automatic t_config();
    apb(1'b1, smlr_pkg::OFF_LOW_LO, 8'hA5);
    apb(1'b1, smlr_pkg::OFF_LOW_HI, 8'hFF);
    apb(1'b1, smlr_pkg::OFF_DW_LO, 8'h34);
    apb(1'b1, smlr_pkg::OFF_DW_HI, 8'h12);
    apb(1'b1, smlr_pkg::OFF_UP_LO, 8'h5A);
    apb(1'b1, smlr_pkg::OFF_UP_HI, 8'hE3);
    apb(1'b1, smlr_pkg::OFF_DSYNC, 8'hFF);
    apb(1'b1, smlr_pkg::OFF_SYNC, 8'hFF);
    repeat (2) @(posedge clk);
    chk(dc_sync_mode, 2'h3);
    chk(monitor_sync_mode, 2'h3);
    rd(smlr_pkg::OFF_SYNC, 8'h03);
    chk(level_lower_threshold, 13'h1FA5);
    chk(level_dwell, 16'h1234);
    chk(level_upper_threshold, 13'h035A);
    chk(tuning_oscillator_reset, 1'b1);
    rd(smlr_pkg::OFF_DSYNC, 8'h13);
    apb(1'b1, 12'h940, 8'hFF);
    chk(perr, 1'b1);
    apb(1'b1, smlr_pkg::OFF_RES0, 8'hFF);
    rd(smlr_pkg::OFF_RES0, 8'h00);
  endtask

  // Period of 4 strobes; the strobe that ends a period seeds the next one's peak
  task automatic t_peak();
    apb(1'b1, smlr_pkg::OFF_PER0, 8'h04);
    apb(1'b1, smlr_pkg::OFF_MCTL, 8'h02);
    repeat (3) pulse(13'h1FFF);
    pulse(13'h0ABC);
    pulse(13'h0123);
    apb(1'b1, smlr_pkg::OFF_RCTL, 8'h11);
    rd(smlr_pkg::OFF_RES0, 8'h00);
    rd(smlr_pkg::OFF_RES1, 8'h5E);
    rd(smlr_pkg::OFF_RES2, 8'h05);
    rd(smlr_pkg::OFF_PCNT, 8'h01);
    rd(smlr_pkg::OFF_RCTL, 8'h01);
    repeat (4) pulse(13'h0FFF);
    rd(smlr_pkg::OFF_PCNT, 8'h01);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_config();
    t_peak();
    give_verdict(0);
  end
endmodule
`default_nettype wire
